/* File: wbr_pkg.sv */
package wbr_pkg;
    // register layout of the warm-boot start address
    localparam int unsigned WBR_REG_W          = 32;
    localparam int unsigned WBR_REV_SEL_HI     = 31;
    localparam int unsigned WBR_REV_SEL_LO     = 30;
    localparam int unsigned WBR_REV_SEL_DRIVE  = 29;
    localparam int unsigned WBR_ADDR_W         = 29;
    localparam logic [31:0] WBR_START_RESET    = 32'h0000_0000;

    // access port word codes (arbitrary encodings for this block)
    localparam logic [31:0] WBR_SYNC_WORD      = 32'h5a5a_0001;
    localparam logic [31:0] WBR_WRITE_START_HDR = 32'h5a5a_0002;
    localparam logic [31:0] WBR_WRITE_CMD_HDR  = 32'h5a5a_0003;
    localparam logic [31:0] WBR_CMD_REPROGRAM  = 32'h0000_0001;

    // clearing and loading
    localparam int unsigned WBR_CLEAR_TIME_NS  = 1000;
    localparam int unsigned WBR_CLK_PERIOD_NS  = 50;
    localparam int unsigned WBR_CLEAR_CYCLES   =
        (WBR_CLEAR_TIME_NS + WBR_CLK_PERIOD_NS - 1) / WBR_CLK_PERIOD_NS;
    localparam int unsigned WBR_CLR_CNT_W      = 16;
    localparam int unsigned WBR_CFG_AW         = 8;

    typedef enum logic [2:0] {
        WBR_IDLE     = 3'b000,
        WBR_SYNCED   = 3'b001,
        WBR_GOT_SADR = 3'b010,
        WBR_GOT_CMDH = 3'b011,
        WBR_CLEAR    = 3'b100,
        WBR_LOAD     = 3'b101,
        WBR_DONE     = 3'b110
    } wbr_state_type;
endpackage

/* File: wbr_config_clear.sv */
`timescale 1ns/1ps
module wbr_config_clear
    import wbr_pkg::*;
#(
    parameter int unsigned CFG_DEPTH = 256
) (
    // clock and reset
    input  wire logic                   mclk_in,
    input  wire logic                   rst_n_in,
    // clearing control
    input  wire logic                   clear_start_in,
    output logic                        clear_busy_out,
    // configuration storage write from the loader
    input  wire logic                   load_we_in,
    input  wire logic [WBR_CFG_AW-1:0]  load_addr_in,
    input  wire logic [31:0]            load_data_in,
    // configured contents read
    input  wire logic [WBR_CFG_AW-1:0]  cfg_raddr_in,
    output logic [31:0]                 cfg_rdata_out
);
    logic [31:0]              cfg_mem [CFG_DEPTH];
    logic [WBR_CFG_AW-1:0]    clr_addr;
    logic [WBR_CLR_CNT_W-1:0] clr_cnt;

    // clear sweeps every entry while counting out the minimum clear time, busy ends when both are done
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            clear_busy_out <= 1'b0;
            clr_addr       <= '0;
            clr_cnt        <= '0;
        end else if (clear_start_in) begin
            clear_busy_out <= 1'b1;
            clr_addr       <= '0;
            clr_cnt        <= '0;
        end else if (clear_busy_out) begin
            if (clr_addr != WBR_CFG_AW'(CFG_DEPTH - 1)) begin
                clr_addr <= clr_addr + 1'b1;
            end
            if (clr_cnt != WBR_CLR_CNT_W'(WBR_CLEAR_CYCLES)) begin
                clr_cnt <= clr_cnt + 1'b1;
            end
            if (clr_addr == WBR_CFG_AW'(CFG_DEPTH - 1) &&
                clr_cnt == WBR_CLR_CNT_W'(WBR_CLEAR_CYCLES)) begin
                clear_busy_out <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (clear_busy_out) begin
            cfg_mem[clr_addr] <= '0;
        end else if (load_we_in) begin
            cfg_mem[load_addr_in] <= load_data_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cfg_rdata_out <= '0;
        end else begin
            cfg_rdata_out <= cfg_mem[cfg_raddr_in];
        end
    end
endmodule

/* File: wbr_reconfig.sv */
`timescale 1ns/1ps
// How it works
// - top two bits feed revision select pins
// - bit 29 chooses drive or tri-state
// - low 29 bits give flash address
// - reprogram command uses current register content
// - command word sequence triggers warm boot
// - boot clears contents, keeps start register
// - reload reads flash from stored address
module wbr_reconfig
    import wbr_pkg::*;
#(
    parameter int unsigned CFG_DEPTH = 256
) (
    // clock and reset
    input  wire logic                   mclk_in,
    input  wire logic                   rst_n_in,
    // internal configuration access port
    input  wire logic                   cap_write_in,
    input  wire logic [31:0]            cap_data_in,
    input  wire logic                   cap_read_in,
    output logic                        cap_ready_out,
    output logic [31:0]                 cap_rdata_out,
    // configuration flash read
    output logic                        flash_req_out,
    output logic [WBR_ADDR_W-1:0]       flash_addr_out,
    input  wire logic                   flash_valid_in,
    input  wire logic [31:0]            flash_data_in,
    input  wire logic                   flash_last_in,
    // revision select pins
    output logic [1:0]                  revision_select_pins_out,
    output logic [1:0]                  revision_select_pins_oe_out,
    // configured contents and status
    input  wire logic [WBR_CFG_AW-1:0]  cfg_raddr_in,
    output logic [31:0]                 cfg_rdata_out,
    output logic                        warm_boot_busy_out,
    output logic                        config_done_out
);
    logic [31:0]           warm_boot_start_address;
    logic [31:0]           boot_address;
    wbr_state_type         state;
    wbr_state_type         next_state;
    logic                  clear_start;
    logic                  clear_busy;
    logic                  clear_seen;
    logic [WBR_CFG_AW-1:0] load_addr;
    logic                  load_we;

    // words are refused while the contents are cleared or loaded
    assign cap_ready_out = (state != WBR_CLEAR) && (state != WBR_LOAD);
    // a flash word lands in the contents only while loading
    assign load_we       = (state == WBR_LOAD) && flash_valid_in;

    // command word decoder
    always_comb begin
        next_state = state;
        case (state)
            WBR_IDLE: begin
                if (cap_write_in && cap_data_in == WBR_SYNC_WORD) begin
                    next_state = WBR_SYNCED;
                end
            end
            WBR_SYNCED, WBR_DONE: begin
                if (cap_write_in) begin
                    if (cap_data_in == WBR_WRITE_START_HDR) begin
                        next_state = WBR_GOT_SADR;
                    end else if (cap_data_in == WBR_WRITE_CMD_HDR) begin
                        next_state = WBR_GOT_CMDH;
                    end
                end
            end
            WBR_GOT_SADR: begin
                if (cap_write_in) begin
                    next_state = WBR_SYNCED;
                end
            end
            WBR_GOT_CMDH: begin
                if (cap_write_in) begin
                    next_state = (cap_data_in == WBR_CMD_REPROGRAM) ? WBR_CLEAR : WBR_SYNCED;
                end
            end
            WBR_CLEAR: begin
                if (clear_seen && !clear_busy) begin
                    next_state = WBR_LOAD;
                end
            end
            WBR_LOAD: begin
                if (flash_valid_in && flash_last_in) begin
                    next_state = WBR_DONE;
                end
            end
            default: next_state = WBR_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            state <= WBR_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // start register survives the warm boot clear
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            warm_boot_start_address <= WBR_START_RESET;
        end else if (state == WBR_GOT_SADR && cap_write_in) begin
            warm_boot_start_address <= cap_data_in;
        end
    end

    // the address is captured when the command arrives
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            boot_address <= WBR_START_RESET;
        end else if (state == WBR_GOT_CMDH && cap_write_in && cap_data_in == WBR_CMD_REPROGRAM) begin
            boot_address <= warm_boot_start_address;
        end
    end

    // one-cycle start pulse for the clearing sweep
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            clear_start <= 1'b0;
        end else begin
            clear_start <= (state != WBR_CLEAR) && (next_state == WBR_CLEAR);
        end
    end

    // sweep has begun, so an idle busy before it is not taken as its end
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            clear_seen <= 1'b0;
        end else if (state != WBR_CLEAR) begin
            clear_seen <= 1'b0;
        end else if (clear_busy) begin
            clear_seen <= 1'b1;
        end
    end

    // flash read from the stored start address
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            flash_req_out  <= 1'b0;
            flash_addr_out <= '0;
            load_addr      <= '0;
        end else if (state == WBR_CLEAR && clear_seen && !clear_busy) begin
            flash_req_out  <= 1'b1;
            flash_addr_out <= boot_address[WBR_ADDR_W-1:0];
            load_addr      <= '0;
        end else if (load_we) begin
            flash_addr_out <= flash_addr_out + 1'b1;
            load_addr      <= load_addr + 1'b1;
            if (flash_last_in) begin
                flash_req_out <= 1'b0;
            end
        end
    end

    // revision select pins follow the register, one flop pair per pin
    for (genvar i = 0; i < WBR_REV_SEL_HI - WBR_REV_SEL_LO + 1; i++) begin : g_rev_sel
        always_ff @(posedge mclk_in) begin
            if (!rst_n_in) begin
                revision_select_pins_out[i]    <= 1'b0;
                revision_select_pins_oe_out[i] <= 1'b0;
            end else begin
                revision_select_pins_out[i]    <= warm_boot_start_address[WBR_REV_SEL_LO + i];
                revision_select_pins_oe_out[i] <= warm_boot_start_address[WBR_REV_SEL_DRIVE];
            end
        end
    end

    // read data stands until the next read strobe
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            cap_rdata_out <= '0;
        end else if (cap_read_in) begin
            cap_rdata_out <= warm_boot_start_address;
        end
    end

    // busy mirrors the clearing and loading states
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            warm_boot_busy_out <= 1'b0;
        end else begin
            warm_boot_busy_out <= (next_state == WBR_CLEAR) || (next_state == WBR_LOAD);
        end
    end

    // done stays up from the end of one load to the next reprogram
    always_ff @(posedge mclk_in) begin
        if (!rst_n_in) begin
            config_done_out <= 1'b0;
        end else if (next_state == WBR_CLEAR) begin
            config_done_out <= 1'b0;
        end else if (next_state == WBR_DONE) begin
            config_done_out <= 1'b1;
        end
    end

    wbr_config_clear #(
        .CFG_DEPTH (CFG_DEPTH)
    ) u_clear (
        .mclk_in        (mclk_in),
        .rst_n_in       (rst_n_in),
        .clear_start_in (clear_start),
        .clear_busy_out (clear_busy),
        .load_we_in     (load_we),
        .load_addr_in   (load_addr),
        .load_data_in   (flash_data_in),
        .cfg_raddr_in   (cfg_raddr_in),
        .cfg_rdata_out  (cfg_rdata_out)
    );
endmodule

/* File: wbr_reconfig_asserts.sv */
`timescale 1ns/1ps
module wbr_reconfig_asserts
    import wbr_pkg::*;
#(
    parameter int unsigned CFG_DEPTH = 256
) (
    // clock and reset
    input wire logic        mclk_in,
    input wire logic        rst_n_in,
    // access port
    input wire logic        cap_write_in,
    input wire logic [31:0] cap_data_in,
    input wire logic        cap_read_in,
    input wire logic        cap_ready_out,
    input wire logic [31:0] cap_rdata_out,
    // flash and pins
    input wire logic        flash_req_out,
    input wire logic [28:0] flash_addr_out,
    input wire logic        flash_valid_in,
    input wire logic        flash_last_in,
    input wire logic [1:0]  revision_select_pins_out,
    input wire logic [1:0]  revision_select_pins_oe_out,
    // status
    input wire logic        warm_boot_busy_out,
    input wire logic        config_done_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_word(logic [31:0] w);
        cap_write_in && cap_ready_out && cap_data_in == w;
    endsequence
    sequence s_reprog;
        s_word(WBR_WRITE_CMD_HDR) ##1 s_word(WBR_CMD_REPROGRAM);
    endsequence
    property p_rev_sel;
        cap_read_in && !cap_write_in |=> revision_select_pins_out == cap_rdata_out[31:30];
    endproperty
    property p_oe;
        cap_read_in && !cap_write_in |=> revision_select_pins_oe_out == {2{cap_rdata_out[29]}};
    endproperty
    property p_start_addr;
        logic [31:0] v;
        (s_word(WBR_WRITE_START_HDR) ##1 (cap_write_in, v = cap_data_in) ##1 s_reprog)
            |-> ##[20:600] ($rose(flash_req_out) && flash_addr_out == v[28:0]);
    endproperty
    property p_busy;
        s_reprog |-> ##[1:2] (warm_boot_busy_out && !cap_ready_out);
    endproperty
    property p_clear_first;
        $rose(warm_boot_busy_out) |-> !flash_req_out [*8];
    endproperty
    property p_incr;
        flash_req_out && flash_valid_in && !flash_last_in |=> flash_addr_out == $past(flash_addr_out) + 29'h1;
    endproperty
    property p_done;
        flash_req_out && flash_valid_in && flash_last_in |=> config_done_out && !flash_req_out && !warm_boot_busy_out;
    endproperty
    property p_reset;
        $rose(rst_n_in) |-> cap_ready_out && !warm_boot_busy_out && !flash_req_out && !config_done_out;
    endproperty
    a_rev_sel: assert property (p_rev_sel) else $error("pins differ from start bits");
    a_oe: assert property (p_oe) else $error("pin enable differs from drive bit");
    a_start_addr: assert property (p_start_addr) else $error("load address wrong");
    a_busy: assert property (p_busy) else $error("reprogram not started");
    a_clear_first: assert property (p_clear_first) else $error("load before clear");
    a_incr: assert property (p_incr) else $error("flash address not advanced");
    a_done: assert property (p_done) else $error("load not finished");
    a_reset: assert property (p_reset) else $error("outputs not idle after reset");
endmodule

/* File: wbr_host_model.sv */
`timescale 1ns/1ps
module wbr_host_model
    import wbr_pkg::*;
(
    // access port handshake
    input  wire logic        mclk_in,
    input  wire logic        cap_ready_in,
    output logic             cap_write_out = 1'b0,
    output logic [31:0]      cap_data_out  = 32'h0
);
    localparam logic [31:0] UPDATE_IMAGE = 32'h0100_0000;
    // the start value is the given word moved six places up in the register
    function automatic logic [31:0] to_start(input logic [31:0] a);
        return a << 6;
    endfunction
    // cmd other than the reprogram word exercises an ignored command; no ready wait exercises refused words
    task automatic reprogram(input logic [31:0] sv, input logic [31:0] cmd = WBR_CMD_REPROGRAM,
                             input bit wait_rdy = 1'b1);
        logic [31:0] w [5];
        int n;
        w = '{WBR_SYNC_WORD, WBR_WRITE_START_HDR, sv, WBR_WRITE_CMD_HDR, cmd};
        n = 0;
        @(posedge mclk_in);
        while (wait_rdy && !cap_ready_in && n < 1000) begin
            @(posedge mclk_in);
            n++;
        end
        for (int i = 0; i < 5; i++) begin
            cap_write_out <= 1'b1;
            cap_data_out <= w[i];
            @(posedge mclk_in);
        end
        cap_write_out <= 1'b0;
        cap_data_out <= ~sv;
    endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
    import wbr_pkg::*;
    localparam int NW = 4;
    logic mclk_in = 0, rst_n_in = 0, cap_read_in = 0, flash_valid_in = 0, flash_last_in = 0;
    logic cap_write_in, cap_ready_out, flash_req_out, warm_boot_busy_out, config_done_out;
    logic [31:0] cap_data_in, cap_rdata_out, cfg_rdata_out, flash_data_in = 32'h0;
    logic [28:0] flash_addr_out;
    logic [7:0] cfg_raddr_in = 8'h0;
    logic [1:0] revision_select_pins_out, revision_select_pins_oe_out;
    int failures = 0, compares = 0, cycles = 0, fcnt = 0;
    always #25 mclk_in = ~mclk_in;
    wbr_host_model host_u (.mclk_in(mclk_in), .cap_ready_in(cap_ready_out), .cap_write_out(cap_write_in),
        .cap_data_out(cap_data_in));
    wbr_reconfig dut_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in), .cap_write_in(cap_write_in),
        .cap_data_in(cap_data_in), .cap_read_in(cap_read_in), .cap_ready_out(cap_ready_out),
        .cap_rdata_out(cap_rdata_out), .flash_req_out(flash_req_out), .flash_addr_out(flash_addr_out),
        .flash_valid_in(flash_valid_in), .flash_data_in(flash_data_in), .flash_last_in(flash_last_in),
        .revision_select_pins_out(revision_select_pins_out), .revision_select_pins_oe_out(revision_select_pins_oe_out),
        .cfg_raddr_in(cfg_raddr_in), .cfg_rdata_out(cfg_rdata_out), .warm_boot_busy_out(warm_boot_busy_out),
        .config_done_out(config_done_out));
    // run ceiling: two loads of under 300 cycles each fit well inside it
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures = failures + 1;
            stop_test();
        end
    end
    // slow flash: one word every other cycle, data idles inverted
    always @(posedge mclk_in) begin
        flash_valid_in <= flash_req_out && !flash_valid_in && fcnt < NW;
        flash_last_in <= flash_req_out && !flash_valid_in && fcnt == NW - 1;
        flash_data_in <= (flash_req_out && !flash_valid_in) ? {3'h5, flash_addr_out} : ~flash_data_in;
        if (!flash_req_out) fcnt <= 0;
        else if (!flash_valid_in) fcnt <= fcnt + 1;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic read_start(output logic [31:0] v);
        @(posedge mclk_in);
        cap_read_in <= 1'b1;
        @(posedge mclk_in);
        cap_read_in <= 1'b0;
        @(posedge mclk_in);
        #1 v = cap_rdata_out;
    endtask
    task automatic t_boot(input string name, input logic [31:0] sv);
        logic [31:0] v;
        int n;
        host_u.reprogram(sv);
        repeat (2) @(posedge mclk_in);
        #1 check("busy", warm_boot_busy_out, 1);
        check("ready", cap_ready_out, 0);
        // a full sequence sent while clearing must be ignored
        host_u.reprogram(~sv, WBR_CMD_REPROGRAM, 1'b0);
        #1 check("busy_kept", warm_boot_busy_out, 1);
        n = 0;
        while (!config_done_out && n < 2000) begin
            @(posedge mclk_in);
            n++;
        end
        #1 check("done", config_done_out, 1);
        for (int k = 0; k <= NW; k++) begin
            @(posedge mclk_in);
            cfg_raddr_in <= 8'(k);
            repeat (2) @(posedge mclk_in);
            #1 check("cfg", cfg_rdata_out, k < NW ? {3'h5, sv[28:0] + 29'(k)} : 32'h0);
        end
        read_start(v);
        check("start", v, sv);
        check("pins", revision_select_pins_out, sv[31:30]);
        check("pins_oe", revision_select_pins_oe_out, {2{sv[29]}});
        $display("test %s done", name);
    endtask
    task automatic stop_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic t_reset();
        logic [31:0] v;
        read_start(v);
        check("reset_start", v, WBR_START_RESET);
        check("reset_ready", cap_ready_out, 1);
        check("reset_done", config_done_out, 0);
        check("reset_pins_oe", revision_select_pins_oe_out, 0);
        check("convert", host_u.to_start(host_u.UPDATE_IMAGE), 32'h4000_0000);
        $display("test reset done");
    endtask
    task automatic t_wrong_cmd(input logic [31:0] sv);
        logic [31:0] v;
        host_u.reprogram(sv, ~WBR_CMD_REPROGRAM);
        repeat (2) @(posedge mclk_in);
        #1 check("no_boot", warm_boot_busy_out, 0);
        check("still_ready", cap_ready_out, 1);
        check("done_kept", config_done_out, 1);
        read_start(v);
        check("start_new", v, sv);
        check("pins_oe_new", revision_select_pins_oe_out, {2{sv[29]}});
        $display("test wrong_cmd done");
    endtask
    initial begin
        repeat (20) @(posedge mclk_in);
        rst_n_in <= 1'b1;
        @(posedge mclk_in);
        t_reset();
        t_boot("update_image", host_u.to_start(host_u.UPDATE_IMAGE));
        t_wrong_cmd(32'h2000_0456);
        t_boot("driven_pins", 32'ha000_0123);
        stop_test();
    end
endmodule
bind wbr_reconfig wbr_reconfig_asserts #(.CFG_DEPTH(CFG_DEPTH)) chk_u (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .cap_write_in(cap_write_in), .cap_data_in(cap_data_in), .cap_read_in(cap_read_in), .cap_ready_out(cap_ready_out),
    .cap_rdata_out(cap_rdata_out), .flash_req_out(flash_req_out), .flash_addr_out(flash_addr_out),
    .flash_valid_in(flash_valid_in), .flash_last_in(flash_last_in), .revision_select_pins_out(revision_select_pins_out),
    .revision_select_pins_oe_out(revision_select_pins_oe_out), .warm_boot_busy_out(warm_boot_busy_out),
    .config_done_out(config_done_out));
